//--- rtl/dtbm_defines.svh
// Timing counts and field constants for the data-transfer-bus master controller
`ifndef DTBM_DEFINES_SVH
`define DTBM_DEFINES_SVH
// ----------------------------------------------------------------------------
// Clock and bus timing
// ----------------------------------------------------------------------------
`define DTBM_CLK_PERIOD_NS 4
`define DTBM_ADDR_SETUP_NS 10
`define DTBM_ADDR_SETUP_CYC ((`DTBM_ADDR_SETUP_NS + `DTBM_CLK_PERIOD_NS - 1) / `DTBM_CLK_PERIOD_NS)
`define DTBM_STROBE_HIGH_NS 40
`define DTBM_STROBE_HIGH_CYC ((`DTBM_STROBE_HIGH_NS + `DTBM_CLK_PERIOD_NS - 1) / `DTBM_CLK_PERIOD_NS)
`define DTBM_CNT_W 4
// ----------------------------------------------------------------------------
// Data lanes
// ----------------------------------------------------------------------------
`define DTBM_ODD_LSB 0
`define DTBM_EVEN_LSB 8
`define DTBM_HIGH_LSB 16
`endif

//--- rtl/dtbm_pkg.sv
// Types shared by the data-transfer-bus master controller and its users
package dtbm_pkg;
   // ----------------------------------------------------------------------------
   // Transfer sizes and completion codes
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      DTBM_SIZE_BYTE = 2'h0,
      DTBM_SIZE_WORD = 2'h1,
      DTBM_SIZE_LONG = 2'h2
   } dtbm_size_type;
   typedef enum logic [1:0] {
      DTBM_RESP_OK = 2'h0,
      DTBM_RESP_BERR = 2'h1,
      DTBM_RESP_ILLEGAL = 2'h2
   } dtbm_resp_code_type;
   // ----------------------------------------------------------------------------
   // Handshake states, one-hot
   // ----------------------------------------------------------------------------
   typedef enum logic [5:0] {
      DTBM_IDLE = 6'h01,
      DTBM_ADDR = 6'h02,
      DTBM_WAIT_FREE = 6'h04,
      DTBM_WAIT_ACK = 6'h08,
      DTBM_TERM = 6'h10,
      DTBM_REL = 6'h20
   } dtbm_state_type;
   // ----------------------------------------------------------------------------
   // User request and answer
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [5:0] am;
      logic write;
      dtbm_size_type size;
      logic [31:0] wdata;
   } dtbm_req_type;
   typedef struct packed {
      dtbm_resp_code_type code;
      logic [31:0] rdata;
   } dtbm_resp_type;
   // ----------------------------------------------------------------------------
   // Bus pins; every enable is low while this end drives
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [31:1] addr;
      logic [5:0] am;
      logic addr_oe_n;
      logic lword_n;
      logic write_n;
      logic iack_n;
      logic ctl_oe_n;
      logic as_n;
      logic ds0_n;
      logic ds1_n;
      logic strobe_oe_n;
      logic [31:0] data;
      logic data_oe_n;
   } dtbm_pin_out_type;
   typedef struct packed {
      logic dtack_n;
      logic berr_n;
      logic [31:0] data;
   } dtbm_pin_in_type;
   // ----------------------------------------------------------------------------
   // Whole state of the controller
   // ----------------------------------------------------------------------------
   typedef struct packed {
      dtbm_state_type fsm;
      logic [3:0] cnt;
      logic plan_ds0_n;
      logic plan_ds1_n;
      logic [1:0] lane;
      dtbm_pin_in_type sync1;
      dtbm_pin_in_type sync2;
      dtbm_pin_out_type pins;
      logic ready;
      logic done;
      dtbm_resp_type resp;
   } dtbm_st_type;
endpackage

//--- rtl/dtbm_master.sv
// Data-transfer-bus master: runs one interlocked strobe/acknowledge cycle per legal user request
`timescale 1ns/1ns
`include "dtbm_defines.svh"

// Functional notes
// - Longword with A01 high is illegal.
// - Longword needs both strobes; every transfer one.
// - Write-select high reads, low writes.
// - Address, modifier, longword stable before address strobe.
// - Interrupt-acknowledge held high for data cycles.
// - Strobes wait for acknowledge and error high.
// - Odd byte read uses odd strobe, low lane.
// - Master captures, raises strobes, then releases them.
// - Word write drives both strobes, lanes 0-15.
// - Longword write adds longword-select, lanes 0-31.
// - Even byte upper lane, odd byte lower.
module dtbm_master
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic req_valid,
   input dtbm_pkg::dtbm_req_type req,
   output logic req_ready,
   output logic resp_valid,
   output dtbm_pkg::dtbm_resp_type resp,
   output dtbm_pkg::dtbm_pin_out_type pins_out,
   input dtbm_pkg::dtbm_pin_in_type pins_in
);
   import dtbm_pkg::*;

   localparam logic [3:0] SETUP_CYC = 4'(`DTBM_ADDR_SETUP_CYC);
   localparam logic [3:0] HIGH_CYC = 4'(`DTBM_STROBE_HIGH_CYC);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   // Misaligned or strobe-less combinations never reach the bus
   function automatic logic is_illegal(input dtbm_req_type r);
      logic bad;
      bad = 1'b0;
      if (r.size == DTBM_SIZE_LONG && (r.addr[1] || r.addr[0]))
      begin
         bad = 1'b1;
      end
      if (r.size == DTBM_SIZE_WORD && r.addr[0])
      begin
         bad = 1'b1;
      end
      if (r.size != DTBM_SIZE_BYTE && r.size != DTBM_SIZE_WORD && r.size != DTBM_SIZE_LONG)
      begin
         bad = 1'b1;
      end
      return bad;
   endfunction

   // Lane code: 0 odd byte, 1 even byte, 2 word, 3 longword
   function automatic logic [1:0] lane_of(input dtbm_req_type r);
      logic [1:0] l;
      l = 2'h2;
      case (r.size)
         DTBM_SIZE_BYTE: l = r.addr[0] ? 2'h0 : 2'h1;
         DTBM_SIZE_LONG: l = 2'h3;
         default: l = 2'h2;
      endcase
      return l;
   endfunction

   // Place user data on the bus lanes; bytes are right-justified on the user side
   function automatic logic [31:0] to_bus(input logic [1:0] l, input logic [31:0] d);
      logic [31:0] v;
      v = 32'h0;
      case (l)
         2'h0: v[`DTBM_ODD_LSB +: 8] = d[7:0];
         2'h1: v[`DTBM_EVEN_LSB +: 8] = d[7:0];
         2'h2: v[15:0] = d[15:0];
         default: v = d;
      endcase
      return v;
   endfunction

   // Pull the strobed lanes back to the user; unstrobed lines are ignored
   function automatic logic [31:0] from_bus(input logic [1:0] l, input logic [31:0] d);
      logic [31:0] v;
      v = 32'h0;
      case (l)
         2'h0: v[7:0] = d[`DTBM_ODD_LSB +: 8];
         2'h1: v[7:0] = d[`DTBM_EVEN_LSB +: 8];
         2'h2: v[15:0] = d[15:0];
         default: v = d;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   dtbm_st_type st;
   dtbm_st_type next_st;

   // Next-state logic
   always_comb
   begin
      next_st = st;
      next_st.sync1 = pins_in;
      next_st.sync2 = st.sync1;
      next_st.done = 1'b0;
      case (st.fsm)
         DTBM_IDLE:
         begin
            if (req_valid)
            begin
               if (is_illegal(req))
               begin
                  // Refused locally: a slave would only answer with bus error anyway
                  next_st.done = 1'b1;
                  next_st.resp.code = DTBM_RESP_ILLEGAL;
                  next_st.resp.rdata = 32'h0;
               end
               else
               begin
                  next_st.lane = lane_of(req);
                  next_st.pins.addr = req.addr[31:1];
                  next_st.pins.am = req.am;
                  next_st.pins.lword_n = (req.size != DTBM_SIZE_LONG);
                  next_st.pins.write_n = ~req.write;
                  next_st.pins.iack_n = 1'b1;
                  next_st.pins.addr_oe_n = 1'b0;
                  next_st.pins.ctl_oe_n = 1'b0;
                  next_st.pins.as_n = 1'b1;
                  next_st.pins.ds0_n = 1'b1;
                  next_st.pins.ds1_n = 1'b1;
                  next_st.pins.strobe_oe_n = 1'b0;
                  next_st.pins.data = to_bus(lane_of(req), req.wdata);
                  next_st.pins.data_oe_n = ~req.write;
                  // Odd strobe for odd byte, even strobe for even byte, both otherwise
                  next_st.plan_ds0_n = (lane_of(req) == 2'h1);
                  next_st.plan_ds1_n = (lane_of(req) == 2'h0);
                  next_st.cnt = SETUP_CYC;
                  next_st.fsm = DTBM_ADDR;
               end
            end
         end
         DTBM_ADDR:
         begin
            // Address group settles before the address strobe falls
            if (st.cnt == 4'h0)
            begin
               next_st.pins.as_n = 1'b0;
               next_st.cnt = SETUP_CYC;
               next_st.fsm = DTBM_WAIT_FREE;
            end
            else
            begin
               next_st.cnt = st.cnt - 4'h1;
            end
         end
         DTBM_WAIT_FREE:
         begin
            // Direction and write data get setup time, then the previous slave must be gone
            if (st.cnt != 4'h0)
            begin
               next_st.cnt = st.cnt - 4'h1;
            end
            else if (st.sync2.dtack_n && st.sync2.berr_n)
            begin
               next_st.pins.ds0_n = st.plan_ds0_n;
               next_st.pins.ds1_n = st.plan_ds1_n;
               next_st.fsm = DTBM_WAIT_ACK;
            end
         end
         DTBM_WAIT_ACK:
         begin
            // No local time-out: a stalled slave is ended by the bus time-out monitor
            if (!st.sync2.dtack_n)
            begin
               next_st.resp.code = DTBM_RESP_OK;
               next_st.resp.rdata = st.pins.write_n ? from_bus(st.lane, st.sync2.data) : 32'h0;
               next_st.fsm = DTBM_TERM;
            end
            else if (!st.sync2.berr_n)
            begin
               next_st.resp.code = DTBM_RESP_BERR;
               next_st.resp.rdata = 32'h0;
               next_st.fsm = DTBM_TERM;
            end
         end
         DTBM_TERM:
         begin
            // Release address and data, drive strobes high
            next_st.pins.addr_oe_n = 1'b1;
            next_st.pins.ctl_oe_n = 1'b1;
            next_st.pins.data_oe_n = 1'b1;
            next_st.pins.as_n = 1'b1;
            next_st.pins.ds0_n = 1'b1;
            next_st.pins.ds1_n = 1'b1;
            next_st.done = 1'b1;
            next_st.cnt = HIGH_CYC;
            next_st.fsm = DTBM_REL;
         end
         DTBM_REL:
         begin
            // Strobes tri-stated one cycle after going high; stay idle-high before the next cycle
            next_st.pins.strobe_oe_n = 1'b1;
            if (st.cnt == 4'h0)
            begin
               next_st.fsm = DTBM_IDLE;
            end
            else
            begin
               next_st.cnt = st.cnt - 4'h1;
            end
         end
         default:
         begin
            next_st.fsm = DTBM_IDLE;
         end
      endcase
      next_st.ready = (next_st.fsm == DTBM_IDLE) && !next_st.done;
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '{fsm: DTBM_IDLE, cnt: 4'h0, plan_ds0_n: 1'b1, plan_ds1_n: 1'b1, lane: 2'h0,
                 sync1: '1, sync2: '1,
                 pins: '{addr: 31'h0, am: 6'h0, addr_oe_n: 1'b1, lword_n: 1'b1, write_n: 1'b1,
                         iack_n: 1'b1, ctl_oe_n: 1'b1, as_n: 1'b1, ds0_n: 1'b1, ds1_n: 1'b1,
                         strobe_oe_n: 1'b1, data: 32'h0, data_oe_n: 1'b1},
                 ready: 1'b0, done: 1'b0,
                 resp: '{code: DTBM_RESP_OK, rdata: 32'h0}};
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------------------
   assign req_ready = st.ready;
   assign resp_valid = st.done;
   assign resp = st.resp;
   assign pins_out = st.pins;
endmodule

//--- tb/dtbm_master_sva.sv
// Concurrent checks on the ports of the data-transfer-bus master
`timescale 1ns/1ns
module dtbm_master_chk
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic req_valid,
   input dtbm_pkg::dtbm_req_type req,
   input wire logic req_ready,
   input wire logic resp_valid,
   input dtbm_pkg::dtbm_resp_type resp,
   input dtbm_pkg::dtbm_pin_out_type pins_out,
   input dtbm_pkg::dtbm_pin_in_type pins_in
);
   import dtbm_pkg::*;
   logic [3:0] ack_age;
   wire bad = (req.size == DTBM_SIZE_LONG && req.addr[1:0] != 2'h0) || (req.size == DTBM_SIZE_WORD && req.addr[0])
      || req.size == 2'h3;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------------
   // Cycles since the bus last showed an answer; saturates so it never wraps
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         ack_age <= 4'hf;
      else if (!pins_in.dtack_n || !pins_in.berr_n)
         ack_age <= 4'h0;
      else if (ack_age != 4'hf)
         ack_age <= ack_age + 4'h1;
   a_setup_before_as: assert property ($fell(pins_out.as_n) |-> !$past(pins_out.addr_oe_n, 3)
      && !$past(pins_out.ctl_oe_n, 3) && $past(pins_out.addr, 3) == pins_out.addr
      && $past(pins_out.lword_n, 3) == pins_out.lword_n) else $error("address not set up");
   a_addr_held: assert property (!pins_out.as_n && !$past(pins_out.as_n) |-> $stable(pins_out.addr)
      && $stable(pins_out.am) && $stable(pins_out.write_n)) else $error("address moved under strobe");
   a_iack_high: assert property (!pins_out.ctl_oe_n |-> pins_out.iack_n)
      else $error("acknowledge line low");
   a_ds_after_as: assert property (!pins_out.ds0_n || !pins_out.ds1_n |-> !pins_out.as_n
      && !pins_out.strobe_oe_n) else $error("data strobe without address strobe");
   // The strobe decision reads the second synchroniser stage, so the bus level it obeyed is three samples back
   a_ds_bus_free: assert property ($fell(pins_out.ds0_n) || $fell(pins_out.ds1_n) |->
      $past(pins_in.dtack_n, 3) && $past(pins_in.berr_n, 3)) else $error("strobe fell while bus busy");
   a_hold_to_ack: assert property ($rose(pins_out.ds0_n) || $rose(pins_out.ds1_n) |-> ack_age < 4'h3)
      else $error("strobe rose without answer");
   a_release_order: assert property ($rose(pins_out.as_n) |-> pins_out.ds0_n && pins_out.ds1_n
      && pins_out.addr_oe_n && !pins_out.strobe_oe_n && resp_valid ##1 pins_out.strobe_oe_n)
      else $error("bad release order");
   a_long_strobes: assert property ((!pins_out.ds0_n || !pins_out.ds1_n) && !pins_out.lword_n
      && !pins_out.ctl_oe_n |-> !pins_out.ds0_n && !pins_out.ds1_n && !pins_out.addr[1])
      else $error("bad longword strobes");
   a_write_dir: assert property (!pins_out.ctl_oe_n |-> pins_out.write_n == pins_out.data_oe_n)
      else $error("data drive against direction");
   a_illegal_fast: assert property (ce && req_valid && req_ready && bad |=> resp_valid
      && resp.code == DTBM_RESP_ILLEGAL && pins_out.strobe_oe_n) else $error("illegal request not refused");
   c_illegal: cover property (resp_valid && resp.code == DTBM_RESP_ILLEGAL);
   c_berr: cover property (resp_valid && resp.code == DTBM_RESP_BERR);
   c_long: cover property (!pins_out.lword_n && !pins_out.ds0_n && !pins_out.write_n);
endmodule

//--- tb/dtbm_slave_model.sv
// Behavioural slave with byte memory and bus time-out monitor
`timescale 1ns/1ns
module dtbm_slave_model
#(
   parameter logic [31:0] BASE = 32'h0000_1000,
   parameter logic [5:0] AM = 6'h09,
   parameter int TO = 24,
   parameter bit NO_LONG = 1'b0
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [3:0] lat,
   input dtbm_pkg::dtbm_pin_out_type pins_out,
   output dtbm_pkg::dtbm_pin_in_type pins_in
);
   import dtbm_pkg::*;
   logic [7:0] mem [64];
   logic dtack_n, berr_n, bto_n, drv;
   logic [31:0] dout, last;
   int w, t;
   wire ds_lo = !pins_out.strobe_oe_n && !(pins_out.ds0_n && pins_out.ds1_n);
   wire both = !pins_out.ds0_n && !pins_out.ds1_n;
   wire lw = !pins_out.ctl_oe_n && !pins_out.lword_n;
   wire sel = !pins_out.strobe_oe_n && !pins_out.as_n && !pins_out.addr_oe_n && pins_out.iack_n
      && pins_out.am == AM && pins_out.addr[31:6] == BASE[31:6];
   wire [5:0] b = {pins_out.addr[5:1], 1'b0};
   // Pull-ups on answer lines; a free data bus shows a changing pattern, not the last value
   assign pins_in = '{dtack_n: dtack_n, berr_n: berr_n & bto_n,
      data: !pins_out.data_oe_n ? pins_out.data : drv ? dout : ~last};
   always @(posedge clk_sys)
      last <= pins_in.data;
   // Slave; sampled on the local clock, which stands in for its synchroniser
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         dtack_n <= 1'b1;
         berr_n <= 1'b1;
         drv <= 1'b0;
         w <= 0;
         foreach (mem[i]) mem[i] <= 8'h00;
      end
      else if (!ds_lo)
      begin
         drv <= 1'b0; // Data freed before acknowledge
         w <= 0;
         berr_n <= 1'b1;
         if (!drv) dtack_n <= 1'b1;
      end
      else if (sel && dtack_n && berr_n)
      begin
         w <= w + 1;
         if (w >= int'(lat))
         begin
            if (lw && (pins_out.addr[1] || !both || NO_LONG)) berr_n <= 1'b0;
            else if (!pins_out.write_n)
            begin
               // Lanes: even byte on D15-D08, odd on D07-D00
               if (lw) for (int k = 0; k < 4; k++) mem[b + k] <= pins_out.data[31 - 8 * k -: 8];
               else
               begin
                  if (!pins_out.ds1_n) mem[b] <= pins_out.data[15:8];
                  if (!pins_out.ds0_n) mem[b + 6'h1] <= pins_out.data[7:0];
               end
               dtack_n <= 1'b0;
            end
            else if (!drv)
            begin
               // Unstrobed lanes carry junk the master must ignore
               drv <= 1'b1;
               dout <= lw ? {mem[b], mem[b + 6'h1], mem[b + 6'h2], mem[b + 6'h3]} : {~mem[b], ~mem[b + 6'h1],
                  pins_out.ds1_n ? ~mem[b] : mem[b], pins_out.ds0_n ? ~mem[b + 6'h1] : mem[b + 6'h1]};
            end
            else dtack_n <= 1'b0; // Data valid a cycle before acknowledge, held while strobed
         end
      end
   // Time-out monitor: counts from strobe fall, stops on answer, frees on strobe rise
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n || !ds_lo)
      begin
         bto_n <= 1'b1;
         t <= 0;
      end
      else if (pins_in.dtack_n && pins_in.berr_n)
      begin
         t <= t + 1;
         if (t == TO) bto_n <= 1'b0;
      end
endmodule

//--- tb/tb.sv
// Self-checking bench for the data-transfer-bus master
`timescale 1ns/1ns
module tb;
   import dtbm_pkg::*;
   localparam logic [31:0] BASE = 32'h0000_1000;
   localparam logic [5:0] AM = 6'h09;
   logic clk_sys, arst_n, ce, req_valid, req_ready, resp_valid;
   logic [3:0] lat;
   dtbm_req_type req, r;
   dtbm_resp_type resp;
   dtbm_pin_out_type pins_out;
   dtbm_pin_in_type pins_in;
   logic [7:0] ref_mem [64];
   int n_fail, total_checks;
   dtbm_master u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .pins_out(pins_out), .pins_in(pins_in));
   dtbm_slave_model #(.BASE(BASE), .AM(AM)) u_slave (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat),
      .pins_out(pins_out), .pins_in(pins_in));
   always #2 clk_sys = ~clk_sys;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic dtbm_req_type mk(input logic wr, input dtbm_size_type sz, input logic [5:0] off,
      input logic [31:0] d);
      return '{addr: BASE | 32'(off), am: AM, write: wr, size: sz, wdata: d};
   endfunction
   // Expected answer; also keeps the reference memory in step with writes
   function automatic logic [33:0] expect_of(input dtbm_req_type q);
      logic [31:0] d;
      int n;
      n = q.size == DTBM_SIZE_LONG ? 4 : q.size == DTBM_SIZE_WORD ? 2 : 1;
      d = 32'h0;
      if (q.size == 2'h3 || (n == 4 && q.addr[1:0] != 2'h0) || (n == 2 && q.addr[0]))
         return {DTBM_RESP_ILLEGAL, 32'h0};
      if (q.addr[31:6] != BASE[31:6] || q.am != AM) return {DTBM_RESP_BERR, 32'h0};
      for (int k = 0; k < n; k++)
         if (q.write) ref_mem[q.addr[5:0] + k] = q.wdata[8 * (n - 1 - k) +: 8];
         else d = {d[23:0], ref_mem[q.addr[5:0] + k]};
      return {DTBM_RESP_OK, q.write ? 32'h0 : d};
   endfunction
   // One request through the user port, bounded waits on ready and answer
   task automatic run(input dtbm_req_type q);
      logic [33:0] e;
      int i;
      e = expect_of(q);
      lat = 4'($urandom_range(0, 5));
      for (i = 0; req_ready !== 1'b1 && i < 100; i++) @(posedge clk_sys) #1;
      // A controller that never turns ready leaves the answer missing, which ends the run below
      if (req_ready === 1'b1)
      begin
         req = q;
         req_valid = 1'b1;
         @(posedge clk_sys) #1;
         req_valid = 1'b0;
         for (i = 0; resp_valid !== 1'b1 && i < 300; i++) @(posedge clk_sys) #1;
      end
      if (resp_valid !== 1'b1)
      begin
         n_fail++;
         end_sim();
      end
      else
      begin
         check({resp.code, resp.rdata}, e);
      end
   endtask
   initial
   begin
      clk_sys = 1'b0;
      arst_n = 1'b0;
      ce = 1'b1;
      req_valid = 1'b0;
      req = '0;
      lat = 4'h0;
      n_fail = 0;
      total_checks = 0;
      foreach (ref_mem[i]) ref_mem[i] = 8'h00;
      void'($urandom(32'h6fb1b8de));
      repeat (10) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      @(posedge clk_sys) #1;
      // Clock enable low: an offered misaligned longword is neither taken nor answered while frozen
      ce = 1'b0;
      req = mk(1'b0, DTBM_SIZE_LONG, 6'h02, 32'h0);
      req_valid = 1'b1;
      repeat (4) @(posedge clk_sys) #1;
      check(34'({resp_valid, req_ready, pins_out.strobe_oe_n}), 34'h3);
      req_valid = 1'b0;
      ce = 1'b1;
      $display("test freeze done");
      @(posedge clk_sys) #1;
      // Longword in, then every byte and the word at offset 6 back out
      run(mk(1'b1, DTBM_SIZE_LONG, 6'h04, 32'ha1b2c3d4));
      for (int k = 0; k < 4; k++) run(mk(1'b0, DTBM_SIZE_BYTE, 6'h04 + 6'(k), 32'h0));
      run(mk(1'b0, DTBM_SIZE_WORD, 6'h06, 32'h0));
      run(mk(1'b1, DTBM_SIZE_WORD, 6'h08, 32'h5a3c));
      run(mk(1'b0, DTBM_SIZE_LONG, 6'h08, 32'h0));
      // Refused shapes back to back, then a cycle nobody answers
      run(mk(1'b0, DTBM_SIZE_LONG, 6'h06, 32'h0));
      run(mk(1'b1, DTBM_SIZE_WORD, 6'h05, 32'h0));
      run(mk(1'b0, dtbm_size_type'(2'h3), 6'h00, 32'h0));
      r = mk(1'b0, DTBM_SIZE_WORD, 6'h00, 32'h0);
      r.am = 6'h3d;
      run(r);
      $display("test corner done");
      for (int j = 0; j < 60; j++)
      begin
         r = mk(1'($urandom), dtbm_size_type'($urandom_range(0, 2)), 6'($urandom), $urandom);
         if (r.size == DTBM_SIZE_LONG) r.addr[1:0] = 2'h0;
         if (r.size == DTBM_SIZE_WORD) r.addr[0] = 1'b0;
         if (r.size == DTBM_SIZE_BYTE) r.wdata = r.wdata & 32'hff;
         if (r.size == DTBM_SIZE_WORD) r.wdata = r.wdata & 32'hffff;
         if ($urandom_range(0, 9) == 0) r.addr[13] = 1'b1;
         run(r);
      end
      $display("test random done");
      end_sim();
   end
endmodule
bind dtbm_master dtbm_master_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .pins_out(pins_out), .pins_in(pins_in));
